// *** coproc_operand_write_stack_primitives_test.sv ***
// Self-checking bench for the coprocessor primitive engine.
// Assumes the side model for operand and memory traffic, Wishbone tasks here.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module coproc_operand_write_stack_primitives_test;
  logic core_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, instr_start = 0;
  logic supervisor = 0, ea_load = 0, prim_valid = 0, slow = 0, exp_we;
  logic wb_ack_o, irq, prim_ready, prim_done, protocol_violation, sp_wr;
  logic opnd_in_valid, opnd_in_ready, opnd_out_valid, opnd_out_ready, mem_valid, mem_ack;
  logic [7:0]  adr = 0, len;
  logic [3:0]  sel = 0;
  logic [2:0]  exp_fc, s;
  logic [8:0]  exp_rem;
  logic [31:0] wdat = 0, ea_value = 0, sp = 32'h0000_8000, ea, rd, exp_addr, exp_sp, m;
  logic [31:0] wb_dat_o, opnd_in_data, opnd_out_data, mem_rdata, sp_wdata, qd[$], qm[$];
  logic [31:0] total = 0;
  logic [7:0]  corner [5] = '{8'h0, 8'h3, 8'h4, 8'h5, 8'hFF};
  coproc_prim_pkg::prim_s    prim = '0;
  coproc_prim_pkg::mem_req_s mem_o;
  int mismatches = 0, compares = 0, seed = 32'h44db, nsp, i;

  coproc_prim u_coproc_prim (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .instr_start(instr_start), .supervisor(supervisor), .ea_load(ea_load),
    .ea_value(ea_value), .prim_valid(prim_valid), .prim(prim), .prim_ready(prim_ready),
    .prim_done(prim_done), .protocol_violation(protocol_violation),
    .opnd_in_valid(opnd_in_valid), .opnd_in_data(opnd_in_data),
    .opnd_in_ready(opnd_in_ready), .opnd_out_valid(opnd_out_valid),
    .opnd_out_data(opnd_out_data), .opnd_out_ready(opnd_out_ready),
    .mem_valid(mem_valid), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .active_stack_pointer(sp), .sp_wr(sp_wr), .sp_wdata(sp_wdata));
  coproc_side_model u_coproc_side_model (.core_clk(core_clk), .reset_n(reset_n),
    .slow(slow), .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .opnd_in_valid(opnd_in_valid), .opnd_in_data(opnd_in_data),
    .opnd_in_ready(opnd_in_ready), .opnd_out_valid(opnd_out_valid),
    .opnd_out_ready(opnd_out_ready));

  always #20 core_clk = ~core_clk;

  // Low-justified byte lanes of a part
  function automatic logic [31:0] szmask(input logic [2:0] n);
    return (n >= 3'h4) ? 32'hFFFF_FFFF : (32'h1 << {n, 3'h0}) - 32'h1;
  endfunction

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    final_report();
  endtask

  // One classic Wishbone cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
    for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge core_clk);
    if (wb_ack_o !== 1'b1) timeout();
    rd = wb_dat_o;
    {cyc, stb} <= 2'h0;
  endtask

  // New instruction, optionally with an evaluated address
  task automatic start(input logic load, input logic [31:0] v);
    @(posedge core_clk);
    {instr_start, ea_load, ea_value} <= {1'b1, load, v};
    @(posedge core_clk);
    {instr_start, ea_load} <= 2'h0;
  endtask

  // Issue one primitive and check its outcome against the expectations
  task automatic issue(input coproc_prim_pkg::prim_kind_e k, input logic [7:0] n,
                       input logic dr, ca, cond, input logic [31:0] a, input logic viol);
    logic [7:0] adj;
    adj = (n == 8'h1) ? 8'h2 : n;
    exp_fc = supervisor ? coproc_prim_pkg::FC_SUPER_DATA : coproc_prim_pkg::FC_USER_DATA;
    exp_we = (k == coproc_prim_pkg::PRIM_WRITE_EA) || dr;
    exp_addr = (k == coproc_prim_pkg::PRIM_WRITE_EA) ? ea : (k == coproc_prim_pkg::PRIM_TAKE)
             ? a : dr ? sp - adj : sp;
    exp_rem = viol ? 9'h0 : {1'b0, n};
    exp_sp = (k == coproc_prim_pkg::PRIM_STACK && !viol) ? (dr ? sp - adj : sp + adj) : 'x;
    nsp = 0;
    @(posedge core_clk);
    prim_valid <= 1'b1;
    prim <= '{kind: k, length: n, direction_bit: dr, come_again_bit: ca, conditional: cond,
              addr: a};
    for (i = 0; i < 50 && prim_ready !== 1'b1; i++) @(posedge core_clk);
    if (prim_ready !== 1'b1) timeout();
    @(posedge core_clk);
    prim_valid <= 1'b0;
    for (i = 0; i < 900 && prim_done !== 1'b1 && protocol_violation !== 1'b1; i++)
      @(posedge core_clk);
    if (prim_done !== 1'b1 && protocol_violation !== 1'b1) timeout();
    `CHK(protocol_violation, viol)
    @(posedge core_clk);
    `CHK(exp_rem, 9'h0)
    `CHK(nsp, (k == coproc_prim_pkg::PRIM_STACK && !viol) ? 1 : 0)
  endtask

  // Memory, operand and stack pointer traffic compared as it happens
  always @(posedge core_clk) begin
    if (mem_valid && mem_ack) begin
      s = (exp_rem >= 9'h4) ? 3'h4 : exp_rem[2:0];
      m = szmask(s);
      `CHK(mem_o.addr, exp_addr)
      `CHK(mem_o.size, s)
      `CHK(mem_o.fc, exp_fc)
      `CHK({mem_o.we, mem_o.lock}, {exp_we, 1'b0})
      if (exp_we) `CHK(mem_o.wdata & m, qd.pop_front() & m)
      else begin
        qd.push_back(mem_rdata & m);
        qm.push_back(m);
      end
      exp_addr += {29'h0, s};
      total += {29'h0, s};
      exp_rem -= {6'h0, s};
    end
    if (opnd_in_valid && opnd_in_ready) qd.push_back(opnd_in_data);
    if (opnd_out_valid && opnd_out_ready && qd.size() > 0)
      `CHK(opnd_out_data & qm.pop_front(), qd.pop_front())
    if (sp_wr) begin
      `CHK(sp_wdata, exp_sp)
      nsp++;
      sp <= sp_wdata;
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(0, coproc_prim_pkg::OFS_CTRL, 0);
    `CHK(rd, coproc_prim_pkg::CTRL_RST)
    wb(0, coproc_prim_pkg::OFS_MASK, 0);
    `CHK(rd[2:0], coproc_prim_pkg::MASK_RST)
    wb(1, 8'h40, 32'hFFFF_FFFF);
    wb(0, 8'h40, 0);
    `CHK(rd, 32'h0)
    $display("test registers ended");
    // Corner and random lengths, always alterable memory targets
    for (int j = 0; j < 8; j++) begin
      len = (j > 4) ? 8'($random(seed)) : corner[j];
      ea = $random(seed);
      {supervisor, slow} <= 2'($random(seed));
      start(1, ea);
      issue(coproc_prim_pkg::PRIM_WRITE_EA, len, 0, 1, 0, 0, 0);
      wb(0, coproc_prim_pkg::OFS_EA, 0);
      `CHK(rd, ea)
      for (int t = 0; t < 2; t++) begin
        issue(coproc_prim_pkg::PRIM_TAKE, 8'($random(seed)), 1'($random(seed)), 1,
              1'($random(seed)), $random(seed), 0);
        `CHK(u_coproc_prim.irq, 1'b0)
      end
      issue(coproc_prim_pkg::PRIM_WRITE_EA, 8'h9, 0, 1, 0, 0, 0);
    end
    $display("test transfers ended");
    issue(coproc_prim_pkg::PRIM_WRITE_EA, 8'h4, 0, 1, 1, 0, 1);
    issue(coproc_prim_pkg::PRIM_TAKE, 8'h4, 1, 0, 1, 32'h100, 1);
    issue(coproc_prim_pkg::PRIM_STACK, 8'h2, 1, 0, 1, 0, 1);
    for (int l = 0; l < 6; l++)
      for (int d = 0; d < 2; d++)
        issue(coproc_prim_pkg::PRIM_STACK, 8'(l), 1'(d), 1, 1'(l & 1), 0,
              !(l == 1 || l == 2 || l == 4));
    $display("test stack ended");
    // Write with no evaluated address, then violation, through the interrupt
    wb(0, coproc_prim_pkg::OFS_STATUS, 0);
    wb(1, coproc_prim_pkg::OFS_MASK, 32'h6);
    start(0, 0);
    issue(coproc_prim_pkg::PRIM_WRITE_EA, 8'h4, 0, 1, 0, 0, 0);
    `CHK(irq, 1'b1)
    wb(0, coproc_prim_pkg::OFS_STATUS, 0);
    `CHK(rd[2:0], 3'h5)
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    issue(coproc_prim_pkg::PRIM_WRITE_EA, 8'h4, 0, 1, 1, 0, 1);
    `CHK(irq, 1'b1)
    wb(0, coproc_prim_pkg::OFS_STATUS, 0);
    `CHK(rd[2:0], 3'h2)
    wb(0, coproc_prim_pkg::OFS_COUNT, 0);
    `CHK(rd, total)
    $display("test interrupts ended");
    final_report();
  end
endmodule // coproc_operand_write_stack_primitives_test

// *** coproc_prim.sv ***
// Main-processor engine for write-to-evaluated-address, take-address
// and top-of-stack coprocessor primitives.
// Assumes synchronous inputs, one clock and a single-beat memory port.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module coproc_prim #(
  parameter int LEN_W = 8
) (
  // Clock, reset, enable
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             irq,
  // Instruction context
  input  wire logic                        instr_start,
  input  wire logic                        supervisor,
  input  wire logic                        ea_load,
  input  wire logic [31:0]                 ea_value,
  // Primitive intake
  input  wire logic                        prim_valid,
  input  wire coproc_prim_pkg::prim_s      prim,
  output logic                             prim_ready,
  output logic                             prim_done,
  output logic                             protocol_violation,
  // Operand interface register
  input  wire logic                        opnd_in_valid,
  input  wire logic [31:0]                 opnd_in_data,
  output logic                             opnd_in_ready,
  output logic                             opnd_out_valid,
  output logic [31:0]                      opnd_out_data,
  input  wire logic                        opnd_out_ready,
  // Data-space memory port
  output logic                             mem_valid,
  output coproc_prim_pkg::mem_req_s        mem_o,
  input  wire logic                        mem_ack,
  input  wire logic [31:0]                 mem_rdata,
  // Active stack pointer
  input  wire logic [31:0]                 active_stack_pointer,
  output logic                             sp_wr,
  output logic [31:0]                      sp_wdata
);

  // Elaboration check: length counters are byte wide
  if (LEN_W != 8) begin : g_bad_len
    $error("coproc_prim: LEN_W must be 8");
  end

  coproc_prim_pkg::state_e state;
  logic [31:0]      temp_ea;
  logic             ea_valid;
  logic [LEN_W-1:0] remaining;
  logic [31:0]      xfer_addr;
  logic             to_mem;
  logic             fc_super;
  logic             pop_pending;
  logic [31:0]      pop_sp;
  logic [31:0]      hold_data;
  logic [31:0]      count;
  logic             enable;
  logic [2:0]       status;
  logic [2:0]       mask;
  logic             accept;
  logic             viol;
  logic             noea;
  logic [2:0]       part;
  logic [7:0]       stack_adj;
  logic             rd_status;

  // Part size: long word while it fits, else the tail
  function automatic logic [2:0] part_of(input logic [7:0] rem);
    part_of = (rem >= 8'(coproc_prim_pkg::PART_MAX)) ? coproc_prim_pkg::PART_MAX : rem[2:0];
  endfunction

  // Handshakes are combinational from state
  assign accept        = prim_valid && prim_ready;
  assign prim_ready    = (state == coproc_prim_pkg::ST_IDLE) && enable;
  assign opnd_in_ready = (state == coproc_prim_pkg::ST_GET);
  assign opnd_out_valid = (state == coproc_prim_pkg::ST_PUT);
  assign mem_valid     = (state == coproc_prim_pkg::ST_MEM);
  assign part          = part_of(remaining);
  assign irq           = |(status & mask);

  // Byte stack operand moves pointer by two to keep it word aligned
  assign stack_adj = (prim.length == coproc_prim_pkg::LEN_BYTE) ?
                     coproc_prim_pkg::BYTE_ADJ : prim.length; // see RULE16 see RULE17

  // Category and length checks at intake
  always_comb begin
    viol = 1'b0;
    if (prim.kind == coproc_prim_pkg::PRIM_WRITE_EA && prim.conditional)
      viol = 1'b1; // see RULE1
    if (prim.kind != coproc_prim_pkg::PRIM_WRITE_EA && prim.conditional &&
        !prim.come_again_bit)
      viol = 1'b1; // see RULE11
    if (prim.kind == coproc_prim_pkg::PRIM_STACK &&
        prim.length != coproc_prim_pkg::LEN_BYTE &&
        prim.length != coproc_prim_pkg::LEN_WORD &&
        prim.length != coproc_prim_pkg::LEN_LONG)
      viol = 1'b1; // see RULE15
  end

  // Write with no evaluated address is flagged but still runs
  assign noea = accept && !viol && !ea_valid &&
                prim.kind == coproc_prim_pkg::PRIM_WRITE_EA; // see RULE4

  // Temporary address: only evaluating primitives load it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_ea  <= 32'h0000_0000;
      ea_valid <= 1'b0;
    end else if (clk_en) begin
      if (ea_load) begin
        temp_ea  <= ea_value; // see RULE3 see RULE8
        ea_valid <= 1'b1;     // see RULE19
      end else if (instr_start) begin
        ea_valid <= 1'b0;     // see RULE19
      end
    end
  end

  // Transfer sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= coproc_prim_pkg::ST_IDLE;
      remaining <= 8'h00;
      xfer_addr <= 32'h0000_0000;
      to_mem    <= 1'b0;
      fc_super  <= 1'b0;
      hold_data <= 32'h0000_0000;
    end else if (clk_en) begin
      case (state)
        coproc_prim_pkg::ST_IDLE: begin
          if (accept && !viol) begin
            remaining <= prim.length; // see RULE2 see RULE12
            fc_super  <= supervisor;  // see RULE5 see RULE14
            // Direction one carries coprocessor data out to memory
            to_mem <= (prim.kind == coproc_prim_pkg::PRIM_WRITE_EA) ||
                      prim.direction_bit; // see RULE18
            case (prim.kind)
              // No alterability check; the stored value is used untouched
              coproc_prim_pkg::PRIM_WRITE_EA:
                xfer_addr <= temp_ea; // see RULE6 see RULE8
              coproc_prim_pkg::PRIM_TAKE:
                xfer_addr <= prim.addr; // see RULE9 see RULE13
              coproc_prim_pkg::PRIM_STACK:
                xfer_addr <= prim.direction_bit ?
                             active_stack_pointer - 32'(stack_adj) : // see RULE17
                             active_stack_pointer;                   // see RULE16
              default:
                xfer_addr <= temp_ea;
            endcase
            if (prim.length == 8'h00)
              state <= coproc_prim_pkg::ST_END;
            else if (prim.kind == coproc_prim_pkg::PRIM_WRITE_EA || prim.direction_bit)
              state <= coproc_prim_pkg::ST_GET;
            else
              state <= coproc_prim_pkg::ST_MEM;
          end
        end
        coproc_prim_pkg::ST_GET: begin
          if (opnd_in_valid) begin
            hold_data <= opnd_in_data;
            state     <= coproc_prim_pkg::ST_MEM;
          end
        end
        coproc_prim_pkg::ST_MEM: begin
          if (mem_ack) begin
            // Ascending addresses, one part per bus cycle
            xfer_addr <= xfer_addr + 32'(part); // see RULE7 see RULE13
            remaining <= remaining - 8'(part);
            if (!to_mem) begin
              hold_data <= mem_rdata;
              state     <= coproc_prim_pkg::ST_PUT;
            end else if (remaining == 8'(part)) begin
              state <= coproc_prim_pkg::ST_END;
            end else begin
              state <= coproc_prim_pkg::ST_GET;
            end
          end
        end
        coproc_prim_pkg::ST_PUT: begin
          if (opnd_out_ready)
            state <= (remaining == 8'h00) ? coproc_prim_pkg::ST_END :
                     coproc_prim_pkg::ST_MEM;
        end
        coproc_prim_pkg::ST_END:
          state <= coproc_prim_pkg::ST_IDLE;
        default:
          state <= coproc_prim_pkg::ST_IDLE;
      endcase
    end
  end

  // Bus request fields; never locked, so a read-modify-write may be split
  assign mem_o.addr  = xfer_addr;
  assign mem_o.size  = part; // see RULE7
  assign mem_o.we    = to_mem;
  assign mem_o.fc    = fc_super ? coproc_prim_pkg::FC_SUPER_DATA :
                       coproc_prim_pkg::FC_USER_DATA; // see RULE5 see RULE14
  assign mem_o.lock  = 1'b0; // see RULE10
  assign mem_o.wdata = hold_data;
  assign opnd_out_data = hold_data;

  // Stack pointer: push updates at intake, pop after the last part
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_wr       <= 1'b0;
      sp_wdata    <= 32'h0000_0000;
      pop_pending <= 1'b0;
      pop_sp      <= 32'h0000_0000;
    end else if (clk_en) begin
      sp_wr <= 1'b0;
      if (accept && !viol && prim.kind == coproc_prim_pkg::PRIM_STACK) begin
        if (prim.direction_bit) begin
          sp_wr    <= 1'b1;
          sp_wdata <= active_stack_pointer - 32'(stack_adj); // see RULE17
        end else begin
          pop_pending <= 1'b1;
          pop_sp      <= active_stack_pointer + 32'(stack_adj); // see RULE16
        end
      end
      if (state == coproc_prim_pkg::ST_END && pop_pending) begin
        sp_wr       <= 1'b1;
        sp_wdata    <= pop_sp;
        pop_pending <= 1'b0;
      end
    end
  end

  // Completion and violation pulses, byte counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prim_done          <= 1'b0;
      protocol_violation <= 1'b0;
      count              <= 32'h0000_0000;
    end else if (clk_en) begin
      prim_done          <= (state == coproc_prim_pkg::ST_END);
      protocol_violation <= accept && viol; // see RULE1 see RULE11 see RULE15
      if (state == coproc_prim_pkg::ST_MEM && mem_ack)
        count <= count + 32'(part);
    end
  end

  // Wishbone: one wait state, ack drops the cycle after it rises
  assign rd_status = wb_ack_o && !wb_we_i && wb_adr_i == coproc_prim_pkg::OFS_STATUS;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      enable   <= coproc_prim_pkg::CTRL_RST[coproc_prim_pkg::CTRL_EN_BIT];
      mask     <= coproc_prim_pkg::MASK_RST;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      // Writes land at the edge where the master sees ack, not before
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == coproc_prim_pkg::OFS_CTRL)
          enable <= wb_dat_i[coproc_prim_pkg::CTRL_EN_BIT];
        if (wb_adr_i == coproc_prim_pkg::OFS_MASK)
          mask <= wb_dat_i[2:0];
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          coproc_prim_pkg::OFS_CTRL:   wb_dat_o <= {31'h0, enable};
          coproc_prim_pkg::OFS_STATUS: wb_dat_o <= {29'h0, status};
          coproc_prim_pkg::OFS_MASK:   wb_dat_o <= {29'h0, mask};
          coproc_prim_pkg::OFS_EA:     wb_dat_o <= temp_ea;
          coproc_prim_pkg::OFS_COUNT:  wb_dat_o <= count;
          default:                     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sticky events; a new event in the clearing cycle survives
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= 3'h0;
    end else if (clk_en) begin
      status <= (rd_status ? 3'h0 : status) |
                {noea, accept && viol, state == coproc_prim_pkg::ST_END};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_cond_write_viol: assert property (clk_en && accept && prim.conditional &&
    prim.kind == coproc_prim_pkg::PRIM_WRITE_EA |=> protocol_violation) // see RULE1
    else $error("write primitive in conditional not refused");

  chk_take_ca_viol: assert property (clk_en && accept && prim.conditional &&
    !prim.come_again_bit && prim.kind != coproc_prim_pkg::PRIM_WRITE_EA
    |=> protocol_violation && state == coproc_prim_pkg::ST_IDLE) // see RULE11
    else $error("come-again clear in conditional not refused");

  chk_stack_len_bad: assert property (clk_en && accept &&
    prim.kind == coproc_prim_pkg::PRIM_STACK && prim.length == 8'h03
    |=> protocol_violation) // see RULE15
    else $error("stack length three not refused");

  chk_write_uses_ea: assert property (clk_en && accept && !viol &&
    prim.kind == coproc_prim_pkg::PRIM_WRITE_EA |=> xfer_addr == $past(temp_ea)) // see RULE3
    else $error("write primitive not at stored address");

  chk_take_keeps_ea: assert property (clk_en && accept && !ea_load &&
    prim.kind == coproc_prim_pkg::PRIM_TAKE |=> temp_ea == $past(temp_ea)) // see RULE9
    else $error("take address disturbed stored address");

  chk_addr_ascend: assert property (clk_en && mem_valid && mem_ack && remaining > 8'h04
    |=> xfer_addr == $past(xfer_addr) + 32'h4) // see RULE7
    else $error("long word parts not ascending by four");

  chk_no_lock: assert property (mem_valid |-> !mem_o.lock &&
    mem_o.size >= 3'h1 && mem_o.size <= 3'h4) // see RULE10
    else $error("locked or oversized bus cycle");

  chk_push_byte_dec: assert property (clk_en && accept && !viol &&
    prim.kind == coproc_prim_pkg::PRIM_STACK && prim.direction_bit &&
    prim.length == 8'h01 |=> sp_wr && sp_wdata == $past(active_stack_pointer) - 32'h2)
    // see RULE17
    else $error("byte push did not pre-decrement by two");

  chk_ea_flag_clear: assert property (clk_en && instr_start && !ea_load |=> !ea_valid)
    // see RULE19
    else $error("address flag not cleared at instruction start");

endmodule // coproc_prim

// *** coproc_prim_pkg.sv ***
// Constants and carriers for the coprocessor operand primitive engine.
// Assumes one 25 MHz core clock and a classic Wishbone register slave.
// Behaviour
// RULE1 - Write-to-evaluated-address accepted in general category only; else violation.
// RULE2 - Write-to-evaluated-address length is 0 to 255 bytes.
// RULE3 - That write targets the temporary address loaded by evaluating primitives only.
// RULE4 - Coprocessor gets an undefined address if none was evaluated or register direct.
// RULE5 - Write function code follows supervisor bit sampled when primitive is read.
// RULE6 - No alterability check on the stored address; coprocessor asks alterable only.
// RULE7 - Long operands go as ascending long words, tail in one transfer.
// RULE8 - The write changes no visible register and uses the stored address as is.
// RULE9 - Take-address never overwrites the stored address nor feeds the write.
// RULE10 - Read then write pair uses plain, unlocked bus cycles.
// RULE11 - Take-address and stack accepted always; conditional with come-again clear violates.
// RULE12 - Take-address length is 0 to 255 bytes.
// RULE13 - Take-address moves the operand as ascending long words, direction per bit.
// RULE14 - Take-address cycles use supervisor or user data space from supervisor bit.
// RULE15 - Stack length must be one, two or four; otherwise violation.
// RULE16 - Direction clear pops from stack, pointer incremented after, byte by two.
// RULE17 - Direction set pushes to stack, pointer decremented first, byte by two.
// RULE18 - Direction bit zero: main to coprocessor; one: coprocessor to main.
// RULE19 - A per-instruction flag marks a loaded temporary address, cleared per instruction.
package coproc_prim_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_EA     = 8'h0C;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int EV_DONE_BIT   = 0;
  localparam int EV_VIOL_BIT   = 1;
  localparam int EV_NOEA_BIT   = 2;
  localparam int EV_W          = 3;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  // Bus function codes
  localparam logic [2:0] FC_USER_DATA  = 3'h1;
  localparam logic [2:0] FC_SUPER_DATA = 3'h5;
  // Transfer sizing
  localparam logic [2:0] PART_MAX   = 3'h4;
  localparam logic [7:0] BYTE_ADJ   = 8'h02;
  localparam logic [7:0] LEN_BYTE   = 8'h01;
  localparam logic [7:0] LEN_WORD   = 8'h02;
  localparam logic [7:0] LEN_LONG   = 8'h04;

  typedef enum logic [1:0] {
    PRIM_WRITE_EA = 2'h0,
    PRIM_TAKE     = 2'h1,
    PRIM_STACK    = 2'h2
  } prim_kind_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GET  = 5'h02,
    ST_MEM  = 5'h04,
    ST_PUT  = 5'h08,
    ST_END  = 5'h10
  } state_e;

  // One decoded primitive from the response register
  typedef struct packed {
    prim_kind_e  kind;
    logic [7:0]  length;
    logic        direction_bit;
    logic        come_again_bit;
    logic        conditional;
    logic [31:0] addr;
  } prim_s;

  // One data-space bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0]  size;
    logic        we;
    logic [2:0]  fc;
    logic        lock;
    logic [31:0] wdata;
  } mem_req_s;
endpackage

// *** coproc_side_model.sv ***
// Far-side model: coprocessor operand register plus data memory.
// Assumes the engine's comb handshakes and single-beat memory requests.
`timescale 1ns/100ps
module coproc_side_model (
  // Clock and pacing
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  // Memory port
  input  wire logic        mem_valid,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // Operand register
  output logic             opnd_in_valid,
  output logic [31:0]      opnd_in_data,
  input  wire logic        opnd_in_ready,
  input  wire logic        opnd_out_valid,
  output logic             opnd_out_ready
);
  logic [1:0]  wait_cnt;
  logic [31:0] word;

  // Memory answers at once or after a stall; idle data keeps toggling
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_valid && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
        mem_ack   <= 1'b1;
        mem_rdata <= ~mem_rdata + 32'h0001_0203;
        wait_cnt  <= 2'h0;
      end else begin
        mem_rdata <= ~mem_rdata;
        wait_cnt  <= wait_cnt + {1'b0, mem_valid};
      end
    end
  end

  // Operand source offers a word once asked; stale data is never shown
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      opnd_in_valid <= 1'b0;
      opnd_in_data  <= 32'h0;
      word          <= 32'hC0DE_0001;
    end else if (opnd_in_valid && opnd_in_ready) begin
      opnd_in_valid <= 1'b0;
      opnd_in_data  <= ~opnd_in_data;
      word          <= word + 32'h1111_1111;
    end else if (opnd_in_ready) begin
      opnd_in_valid <= 1'b1;
      opnd_in_data  <= word;
    end else if (!opnd_in_valid) begin
      opnd_in_data <= ~opnd_in_data;
    end
  end

  // Sink takes each operand part one cycle after it is offered
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      opnd_out_ready <= 1'b0;
    end else begin
      opnd_out_ready <= opnd_out_valid && !opnd_out_ready;
    end
  end
endmodule // coproc_side_model
